// File: eip_core_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Core model: enters the handler of every pending request at once
// ****************************************************************
module eip_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bench control
  input wire logic auto_ack,
  // Core side of the block
  input wire eip_pkg::eip_irq_t irq,
  output var eip_pkg::eip_ack_t core_ack
);
  import eip_pkg::*;

  // A gap after each pulse lets the cleared flag drop before the next entry
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_ack <= '0;
    end else if (auto_ack && core_ack == '0) begin
      core_ack.ext_irq_ack <= irq.ext_irq_request;
      core_ack.pin_change_ack <= irq.pin_change_request_group;
    end else begin
      core_ack <= '0;
    end
  end
endmodule

`default_nettype wire

// File: eip_ext_irq.sv
// How it works
// - A toggle on an enabled input of bank 3..0 raises pin-change group 3..0.
// - Pins are watched whatever their direction, so software writes can interrupt.
// - Pin-change activity is seen on raw input samples, not a gated I/O clock.
// - Two-bit sense select per pin: low level, any edge, falling, rising.
// - Low-level mode keeps requesting, when enabled, while the pin stays low.
// - Low levels and edges on dedicated pins can raise wake while sleeping.
// - A level that vanishes before start-up wakes the part but gives no request.
// - Sense register bits 7:6 read zero; bits 5:0 hold the three selects.
// - Dedicated request needs global enable and its mask bit in bits 2:0.
// - Pulses lasting at least one clock sample produce an interrupt.
// - A configured edge sets the pin flag; core handler entry clears it.
// - Writing one to a dedicated flag clears it; zero leaves it.
// - In low-level mode the dedicated flag is held cleared.
// - Sleep with a pin disabled forces its input low, which may set its flag.
// - Group enable bits 3..0 with the global enable gate the group requests.
// - Only mask-enabled pins of a bank feed that bank's request.
// - Group flag sets on a change; handler entry or writing one clears it.
// - Cleared mask bits block their pins; all masks reset to zero.
`timescale 1ns/1ps
`default_nettype none
`include "eip_params.svh"

module eip_ext_irq (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // AXI4-Lite register port
  input wire eip_pkg::eip_axi_req_t axi_req,
  output var eip_pkg::eip_axi_rsp_t axi_rsp,
  // Pins
  input wire eip_pkg::eip_pins_t pins,
  // Core side
  input wire logic global_irq_enable,
  input wire logic sleep_active,
  input wire eip_pkg::eip_ack_t core_ack,
  output var eip_pkg::eip_irq_t irq
);
  import eip_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [9:0] reg_index(input logic [EIP_ADDR_W-1:0] a);
    return a[11:2];
  endfunction

  function automatic logic reg_mapped(input logic [9:0] idx);
    logic hit;
    hit = 1'b0;
    case (idx)
      `EIP_IDX_PC_FLAGS, `EIP_IDX_EXT_FLAGS, `EIP_IDX_EXT_MASK,
      `EIP_IDX_GRP_EN, `EIP_IDX_SENSE, `EIP_IDX_BANK_MASK0,
      `EIP_IDX_BANK_MASK1, `EIP_IDX_BANK_MASK2, `EIP_IDX_BANK_MASK3: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  function automatic logic [7:0] reg_read(input logic [9:0] idx, input eip_state_t st);
    logic [7:0] v;
    v = `EIP_REG_RESET;
    case (idx)
      `EIP_IDX_PC_FLAGS: v = {4'h0, st.pc_flags};
      `EIP_IDX_EXT_FLAGS: v = {5'h00, st.ext_flags};
      `EIP_IDX_EXT_MASK: v = {5'h00, st.ext_mask};
      `EIP_IDX_GRP_EN: v = {4'h0, st.grp_en};
      `EIP_IDX_SENSE: v = {2'h0, st.sense};
      `EIP_IDX_BANK_MASK0: v = st.bank_mask[0];
      `EIP_IDX_BANK_MASK1: v = st.bank_mask[1];
      `EIP_IDX_BANK_MASK2: v = st.bank_mask[2];
      `EIP_IDX_BANK_MASK3: v = st.bank_mask[3];
      default: v = `EIP_REG_RESET;
    endcase
    return v;
  endfunction

  // Edge qualification for one dedicated pin
  function automatic logic edge_hit(input eip_sense_t mode, input logic prev, input logic cur);
    logic hit;
    hit = 1'b0;
    unique case (mode)
      EIP_SENSE_LOW: hit = 1'b0;
      EIP_SENSE_ANY: hit = prev ^ cur;
      EIP_SENSE_FALL: hit = prev & ~cur;
      EIP_SENSE_RISE: hit = ~prev & cur;
    endcase
    return hit;
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  eip_state_t s;
  eip_state_t n;
  logic [EIP_NUM_DED-1:0] ded_eff;
  logic [EIP_NUM_DED-1:0] ded_event;
  logic [EIP_NUM_DED-1:0] level_low;
  logic [EIP_NUM_DED-1:0] ded_src;
  logic [EIP_NUM_BANKS*8-1:0] pc_change;
  logic wr_fire;
  logic [9:0] wr_idx;
  eip_sense_t mode;

  assign axi_rsp = s.rsp;
  assign irq = s.irq;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    n = s;
    mode = EIP_SENSE_LOW;
    // Asleep with the pin disabled, its input buffer is off and reads low
    ded_eff = pins.dedicated_irq_pins & ~({EIP_NUM_DED{sleep_active}} & ~s.ext_mask);
    // Bus write: address and data are taken independently, in either order
    if (axi_req.awvalid && s.rsp.awready) begin
      n.aw_got = 1'b1;
      n.waddr = axi_req.awaddr;
      n.rsp.awready = 1'b0;
    end
    if (axi_req.wvalid && s.rsp.wready) begin
      n.w_got = 1'b1;
      n.wdata = axi_req.wdata[7:0];
      n.wstrb0 = axi_req.wstrb[0];
      n.rsp.wready = 1'b0;
    end
    wr_fire = n.aw_got && n.w_got;
    wr_idx = reg_index(n.waddr);
    if (wr_fire) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.rsp.bvalid = 1'b1;
      n.rsp.bresp = reg_mapped(wr_idx) ? `EIP_RESP_OKAY : `EIP_RESP_SLVERR;
      // Only byte lane 0 carries register bits
      if (n.wstrb0) begin
        case (wr_idx)
          `EIP_IDX_PC_FLAGS: n.pc_flags = s.pc_flags & ~n.wdata[3:0];
          `EIP_IDX_EXT_FLAGS: n.ext_flags = s.ext_flags & ~n.wdata[2:0];
          `EIP_IDX_EXT_MASK: n.ext_mask = n.wdata[2:0];
          `EIP_IDX_GRP_EN: n.grp_en = n.wdata[3:0];
          `EIP_IDX_SENSE: n.sense = n.wdata[5:0];
          `EIP_IDX_BANK_MASK0: n.bank_mask[0] = n.wdata;
          `EIP_IDX_BANK_MASK1: n.bank_mask[1] = n.wdata;
          `EIP_IDX_BANK_MASK2: n.bank_mask[2] = n.wdata;
          `EIP_IDX_BANK_MASK3: n.bank_mask[3] = n.wdata;
          default: n.ext_mask = s.ext_mask;
        endcase
      end
    end
    if (s.rsp.bvalid && axi_req.bready) begin
      n.rsp.bvalid = 1'b0;
      n.rsp.awready = 1'b1;
      n.rsp.wready = 1'b1;
    end
    // Bus read
    if (axi_req.arvalid && s.rsp.arready) begin
      n.rsp.arready = 1'b0;
      n.rsp.rvalid = 1'b1;
      n.rsp.rdata = {24'h000000, reg_read(reg_index(axi_req.araddr), s)};
      n.rsp.rresp = reg_mapped(reg_index(axi_req.araddr)) ? `EIP_RESP_OKAY : `EIP_RESP_SLVERR;
    end
    if (s.rsp.rvalid && axi_req.rready) begin
      n.rsp.rvalid = 1'b0;
      n.rsp.arready = 1'b1;
    end
    // Handler entry clears flags; an event in the same cycle still wins below
    n.ext_flags = n.ext_flags & ~core_ack.ext_irq_ack;
    n.pc_flags = n.pc_flags & ~core_ack.pin_change_ack;
    // Dedicated pins, sampled regardless of pin direction
    for (int i = 0; i < EIP_NUM_DED; i++) begin
      mode = eip_sense_t'(s.sense[2*i +: 2]);
      ded_event[i] = edge_hit(mode, s.ded_prev[i], ded_eff[i]);
      level_low[i] = (mode == EIP_SENSE_LOW) && !ded_eff[i];
      if (ded_event[i]) begin
        n.ext_flags[i] = 1'b1;
      end
      if (mode == EIP_SENSE_LOW) begin
        n.ext_flags[i] = 1'b0;
      end
      // Level source is live, so a level that vanished gives no request
      ded_src[i] = (mode == EIP_SENSE_LOW) ? level_low[i] : n.ext_flags[i];
    end
    // Pin-change banks: masked inputs against their last sample
    pc_change = (pins.pin_change_inputs ^ s.pc_prev) & s.bank_mask;
    for (int g = 0; g < EIP_NUM_BANKS; g++) begin
      if (|pc_change[8*g +: 8]) begin
        n.pc_flags[g] = 1'b1;
      end
    end
    n.ded_prev = ded_eff;
    n.pc_prev = pins.pin_change_inputs;
    // Requests to the core
    n.irq.ext_irq_request = {EIP_NUM_DED{global_irq_enable}} & n.ext_mask & ded_src;
    n.irq.pin_change_request_group =
      {EIP_NUM_BANKS{global_irq_enable}} & n.grp_en & n.pc_flags;
    // Wake needs no global enable, only the local one
    n.irq.wake_request = sleep_active &&
      ((|(n.ext_mask & ded_src)) || (|(n.grp_en & n.pc_flags)));
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.rsp.awready <= 1'b1;
      s.rsp.wready <= 1'b1;
      s.rsp.arready <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic clr_flag0;
  assign clr_flag0 = wr_fire && n.wstrb0 && (wr_idx == `EIP_IDX_EXT_FLAGS) && n.wdata[0]
    && !ded_event[0];

  sequence s_write_taken;
    axi_req.awvalid && s.rsp.awready && axi_req.wvalid && s.rsp.wready;
  endsequence

  sequence s_write_answered;
    s.rsp.bvalid && !s.rsp.awready && !s.rsp.wready;
  endsequence

  a_write_response: assert property (s_write_taken |=> s_write_answered)
    else $error("write response missing after address and data taken");

  a_read_response: assert property (axi_req.arvalid && s.rsp.arready |=>
    s.rsp.rvalid && !s.rsp.arready)
    else $error("read response missing");

  // Read data must stand unchanged until the master takes it
  a_read_holds: assert property (s.rsp.rvalid && !axi_req.rready |=>
    s.rsp.rvalid && $stable(s.rsp.rdata) && $stable(s.rsp.rresp))
    else $error("read response dropped or changed before rready");

  a_level_clears: assert property (s.sense[1:0] == 2'b00 |=> !s.ext_flags[0])
    else $error("flag set in low-level mode");

  // The request uses the mask as written this cycle, so look at the next mask
  a_level_holds: assert property (global_irq_enable && n.ext_mask[0] && s.sense[1:0] == 2'b00
    && !ded_eff[0] |=> s.irq.ext_irq_request[0])
    else $error("low level not requesting");

  a_global_gate: assert property (!global_irq_enable |=>
    s.irq.ext_irq_request == 3'h0 && s.irq.pin_change_request_group == 4'h0)
    else $error("request without global enable");

  a_rise_sets: assert property (s.sense[1:0] == 2'b11 && !s.ded_prev[0] && ded_eff[0]
    |=> s.ext_flags[0] ##1 (s.ext_flags[0] || $past(core_ack.ext_irq_ack[0]) || $past(clr_flag0)
    || s.sense[1:0] == 2'b00 || $past(s.sense[1:0]) == 2'b00))
    else $error("rising edge did not set flag");

  a_flag_w1c: assert property (clr_flag0 |=> !s.ext_flags[0])
    else $error("write one did not clear flag");

  a_bank_change: assert property (|pc_change[7:0] |=> s.pc_flags[0])
    else $error("bank change did not set group flag");

  a_mask_blocks: assert property (s.bank_mask[0] == 8'h00 && !s.pc_flags[0] |=>
    !s.pc_flags[0] || $past(|(pins.pin_change_inputs[7:0] & s.bank_mask[0])))
    else $error("masked bank set group flag");

  a_ack_clears: assert property (core_ack.pin_change_ack[0] && !(|pc_change[7:0]) |=>
    !s.pc_flags[0])
    else $error("handler entry did not clear group flag");

endmodule

`default_nettype wire

// File: eip_ext_irq_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "eip_params.svh"

module eip_ext_irq_tb_top;
  import eip_pkg::*;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic clk, rst, glob, slp, auto;
  eip_axi_req_t req;
  eip_axi_rsp_t rsp;
  eip_pins_t pins;
  eip_ack_t ack;
  eip_irq_t irq;
  int errors, n_compared;
  logic [9:0] regs [9] = '{`EIP_IDX_PC_FLAGS, `EIP_IDX_EXT_FLAGS, `EIP_IDX_EXT_MASK,
    `EIP_IDX_GRP_EN, `EIP_IDX_SENSE, `EIP_IDX_BANK_MASK0, `EIP_IDX_BANK_MASK1,
    `EIP_IDX_BANK_MASK2, `EIP_IDX_BANK_MASK3};

  eip_ext_irq dut_u (.clk(clk), .rst(rst), .axi_req(req), .axi_rsp(rsp), .pins(pins),
    .global_irq_enable(glob), .sleep_active(slp), .core_ack(ack), .irq(irq));
  eip_core_model core_u (.clk(clk), .rst(rst), .auto_ack(auto), .irq(irq), .core_ack(ack));

  always #50 clk = ~clk;

  // ****************************************************************
  // Checking and bus tasks
  // ****************************************************************
  task automatic give_verdict();
    if (errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      errors++;
    end
  endtask

  // Called right after a rising edge; ends one edge after the release
  task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic [1:0] br;
    br = 2'h3;
    req.awaddr <= {idx, 2'b00};
    req.wdata <= {24'h000000, d};
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    for (int t = 0; t < 50; t++) begin
      @(posedge clk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) begin
        br = rsp.bresp;
        break;
      end
    end
    req.bready <= 1'b0;
    @(posedge clk);
    chk(32'(br), 32'(er));
  endtask

  task automatic rd(input logic [9:0] idx, input logic [1:0] er, output logic [31:0] d);
    logic [1:0] rr;
    rr = 2'h3;
    d = 32'hDEADBEEF;
    req.araddr <= {idx, 2'b00};
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    for (int t = 0; t < 50; t++) begin
      @(posedge clk);
      if (rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) begin
        d = rsp.rdata;
        rr = rsp.rresp;
        break;
      end
    end
    req.rready <= 1'b0;
    @(posedge clk);
    chk(32'(rr), 32'(er));
  endtask

  // ****************************************************************
  // Expectations
  // ****************************************************************
  function automatic logic ev(logic [1:0] s, logic o, logic n);
    case (s)
      EIP_SENSE_ANY: ev = o != n;
      EIP_SENSE_FALL: ev = o & ~n;
      EIP_SENSE_RISE: ev = ~o & n;
      default: ev = 1'b0;
    endcase
  endfunction

  function automatic logic [3:0] pc_exp(logic [31:0] tog, logic [3:0][7:0] bm);
    for (int b = 0; b < 4; b++) pc_exp[b] = |(tog[8*b +: 8] & bm[b]);
  endfunction

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [31:0] d, tog;
    logic [3:0][7:0] bm;
    logic [3:0] ge, pf;
    logic fl, old, nw, g;
    clk = 0;
    rst = 1;
    req = '0;
    pins = '0;
    glob = 0;
    slp = 0;
    auto = 0;
    errors = 0;
    n_compared = 0;
    void'($urandom(92200));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (regs[i]) begin
      rd(regs[i], 2'h0, d);
      chk(d, 32'h0);
    end
    rd(10'h3FF, 2'h2, d);
    chk(d, 32'h0);
    wr(10'h3FF, 8'hFF, 2'h2);
    wr(`EIP_IDX_SENSE, 8'hFF, 2'h0);
    rd(`EIP_IDX_SENSE, 2'h0, d);
    chk(d, 32'h3F);
    pins.dedicated_irq_pins <= 3'h7;
    for (int n = 0; n < 3; n++) begin
      for (int s = 0; s < 4; s++) begin
        // Disable, change sense, clear, re-enable
        wr(`EIP_IDX_EXT_MASK, 8'h00, 2'h0);
        wr(`EIP_IDX_SENSE, 8'(s) << (2 * n), 2'h0);
        wr(`EIP_IDX_EXT_FLAGS, 8'h07, 2'h0);
        wr(`EIP_IDX_EXT_MASK, 8'h01 << n, 2'h0);
        fl = 0;
        old = 1;
        for (int k = 0; k < 6; k++) begin
          nw = 1'($urandom);
          g = 1'($urandom);
          pins.dedicated_irq_pins[n] <= nw;
          glob <= g;
          fl = fl | ev(2'(s), old, nw);
          old = nw;
          // Low level is held across the whole read below
          repeat (2) @(posedge clk);
          rd(`EIP_IDX_EXT_FLAGS, 2'h0, d);
          chk(d, 32'(fl) << n);
          chk(32'(irq.ext_irq_request[n]), 32'(s == 0 ? g & ~nw : g & fl));
        end
        wr(`EIP_IDX_EXT_FLAGS, 8'h00, 2'h0);
        rd(`EIP_IDX_EXT_FLAGS, 2'h0, d);
        chk(d, 32'(fl) << n);
        wr(`EIP_IDX_EXT_FLAGS, 8'h01 << n, 2'h0);
        rd(`EIP_IDX_EXT_FLAGS, 2'h0, d);
        chk(d, 32'h0);
        pins.dedicated_irq_pins[n] <= 1'b1;
      end
    end
    wr(`EIP_IDX_EXT_MASK, 8'h00, 2'h0);
    // Start the sleep check with no dedicated flag left over
    wr(`EIP_IDX_EXT_FLAGS, 8'h07, 2'h0);
    glob <= 1'b1;
    for (int b = 0; b < 4; b++) begin
      bm[b] = 8'($urandom);
      wr(regs[5 + b], bm[b], 2'h0);
    end
    ge = 4'($urandom);
    wr(`EIP_IDX_GRP_EN, {4'h0, ge}, 2'h0);
    for (int k = 0; k < 16; k++) begin
      tog = $urandom;
      pins.pin_change_inputs <= pins.pin_change_inputs ^ tog;
      pf = pc_exp(tog, bm);
      repeat (2) @(posedge clk);
      rd(`EIP_IDX_PC_FLAGS, 2'h0, d);
      chk(d, 32'(pf));
      chk(32'(irq.pin_change_request_group), 32'(pf & ge));
      wr(`EIP_IDX_PC_FLAGS, 8'h0F, 2'h0);
    end
    pins.pin_change_inputs <= ~pins.pin_change_inputs;
    pf = pc_exp(32'hFFFFFFFF, bm);
    glob <= 1'b0;
    slp <= 1'b1;
    repeat (3) @(posedge clk);
    chk(32'(irq.wake_request), 32'(|(pf & ge)));
    chk(32'(irq.pin_change_request_group), 32'h0);
    glob <= 1'b1;
    slp <= 1'b0;
    auto <= 1'b1;
    repeat (6) @(posedge clk);
    rd(`EIP_IDX_PC_FLAGS, 2'h0, d);
    chk(d, 32'(pf & ~ge));
    // Pin 2 read low while asleep and disabled; its rising mode saw the return
    rd(`EIP_IDX_EXT_FLAGS, 2'h0, d);
    chk(d, 32'h4);
    wr(`EIP_IDX_EXT_MASK, 8'h04, 2'h0);
    rd(`EIP_IDX_EXT_FLAGS, 2'h0, d);
    chk(d, 32'h0);
    chk(32'(irq.ext_irq_request), 32'h0);
    give_verdict();
  end

  initial begin
    #2000000;
    errors++;
    give_verdict();
  end
endmodule

`default_nettype wire

// File: eip_params.svh
`ifndef EIP_PARAMS_SVH
`define EIP_PARAMS_SVH

// ****************************************************************
// Register indices (byte address = 4 * index)
// ****************************************************************
`define EIP_IDX_PC_FLAGS 10'h01B
`define EIP_IDX_EXT_FLAGS 10'h01C
`define EIP_IDX_EXT_MASK 10'h01D
`define EIP_IDX_GRP_EN 10'h068
`define EIP_IDX_SENSE 10'h069
`define EIP_IDX_BANK_MASK0 10'h06B
`define EIP_IDX_BANK_MASK1 10'h06C
`define EIP_IDX_BANK_MASK2 10'h06D
`define EIP_IDX_BANK_MASK3 10'h073

// ****************************************************************
// Field layout and reset values
// ****************************************************************
`define EIP_SENSE_FIELD_W 2
`define EIP_BANK_W 8
`define EIP_REG_RESET 8'h00
`define EIP_RESP_OKAY 2'h0
`define EIP_RESP_SLVERR 2'h2

`endif

// File: eip_pkg.sv
package eip_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int EIP_NUM_DED = 3;
  localparam int EIP_NUM_BANKS = 4;
  localparam int EIP_ADDR_W = 12;

  // ****************************************************************
  // Sense select encoding {sense_select_high, sense_select_low}
  // ****************************************************************
  typedef enum logic [1:0] {
    EIP_SENSE_LOW = 2'b00,
    EIP_SENSE_ANY = 2'b01,
    EIP_SENSE_FALL = 2'b10,
    EIP_SENSE_RISE = 2'b11
  } eip_sense_t;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic awvalid;
    logic [EIP_ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [EIP_ADDR_W-1:0] araddr;
    logic rready;
  } eip_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } eip_axi_rsp_t;

  typedef struct packed {
    logic [EIP_NUM_DED-1:0] dedicated_irq_pins;
    logic [EIP_NUM_BANKS*8-1:0] pin_change_inputs;
  } eip_pins_t;

  typedef struct packed {
    logic [EIP_NUM_DED-1:0] ext_irq_ack;
    logic [EIP_NUM_BANKS-1:0] pin_change_ack;
  } eip_ack_t;

  typedef struct packed {
    logic [EIP_NUM_DED-1:0] ext_irq_request;
    logic [EIP_NUM_BANKS-1:0] pin_change_request_group;
    logic wake_request;
  } eip_irq_t;

  typedef struct packed {
    eip_axi_rsp_t rsp;
    logic aw_got;
    logic w_got;
    logic [EIP_ADDR_W-1:0] waddr;
    logic [7:0] wdata;
    logic wstrb0;
    logic [EIP_NUM_DED-1:0] ext_mask;
    logic [EIP_NUM_BANKS-1:0] grp_en;
    logic [2*EIP_NUM_DED-1:0] sense;
    logic [EIP_NUM_DED-1:0] ext_flags;
    logic [EIP_NUM_BANKS-1:0] pc_flags;
    logic [EIP_NUM_BANKS-1:0][7:0] bank_mask;
    logic [EIP_NUM_DED-1:0] ded_prev;
    logic [EIP_NUM_BANKS*8-1:0] pc_prev;
    eip_irq_t irq;
  } eip_state_t;

endpackage
